// ===== hw/dcs_pkg.sv
`default_nettype none
package dcs_pkg;

  // ----------------------------------------------------------------
  // Frame geometry
  // ----------------------------------------------------------------
  localparam int DCS_FRAME_W = 16;
  localparam int DCS_CNT_W = 5;
  localparam int DCS_MOD_W = 3;
  localparam logic [4:0] DCS_MIN_BITS = 5'h10;
  localparam logic [2:0] DCS_MOD_ZERO = 3'h0;
  localparam logic [2:0] DCS_MOD_ONE = 3'h1;
  localparam logic [4:0] DCS_CNT_ONE = 5'h01;

  // ----------------------------------------------------------------
  // Field positions inside the 16-bit command frame
  // ----------------------------------------------------------------
  localparam int DCS_CMD_HI = 15;
  localparam int DCS_CMD_LO = 14;
  localparam int DCS_PADDR_HI = 13;
  localparam int DCS_PADDR_LO = 10;
  localparam int DCS_SADDR_HI = 9;
  localparam int DCS_SADDR_LO = 8;
  localparam int DCS_DATA_HI = 7;
  localparam int DCS_DATA_LO = 0;
  localparam int DCS_PADDR_W = 4;
  localparam int DCS_SADDR_W = 2;
  localparam int DCS_DATA_W = 8;
  localparam int DCS_ADDR_W = 6;

  // ----------------------------------------------------------------
  // Command codes (two leading bits)
  // ----------------------------------------------------------------
  localparam logic [1:0] DCS_CMD_WRITE = 2'h2;
  localparam logic [1:0] DCS_CMD_READ = 2'h1;
  localparam logic [1:0] DCS_CMD_BAD_WRITE = 2'h3;
  localparam logic [1:0] DCS_CMD_BAD_READ = 2'h0;

  // One bit per {primary, secondary} address; set bits are implemented
  localparam logic [63:0] DCS_ADDR_MAP = 64'h0000_0000_0003_ffff;

  // ----------------------------------------------------------------
  // Special response words and read response tag
  // ----------------------------------------------------------------
  localparam logic [15:0] DCS_RSP_RESET = 16'hc001;
  localparam logic [15:0] DCS_RSP_TER = 16'hc002;
  localparam logic [15:0] DCS_RSP_SYNTAX = 16'hc003;
  localparam logic [1:0] DCS_RSP_READ_TAG = 2'h1;

  typedef enum logic [2:0] {
    DCS_SEL_RESET,
    DCS_SEL_TER,
    DCS_SEL_SYNTAX,
    DCS_SEL_DIAG,
    DCS_SEL_READ
  } dcs_rsp_sel_t;

  typedef enum logic {
    DCS_LINK_IDLE,
    DCS_LINK_ACTIVE
  } dcs_link_state_t;

endpackage
`default_nettype wire

// ===== hw/dcs_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dcs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // dcs_sync
`default_nettype wire

// ===== hw/dcs_spi_slave.sv
// Behaviour
// RL1 - Chip select falling edge starts a fresh frame.
// RL2 - Sample input on serial-clock fall, shift output after serial-clock rise.
// RL3 - Host ends each frame by raising chip select; device acts only then.
// RL4 - Decode only with at least 16 clocks and whole bytes; else flag error.
// RL5 - Chip select high: ignore clock and input, output high impedance.
// RL6 - Chip select fall loads the response of the previous command.
// RL7 - Chip select fall drives output to error flag OR input level.
// RL8 - In sleep, chip select fall leaves output off, no transfer.
// RL9 - Valid release writes shift register into the addressed register.
// RL10 - Host keeps serial clock low around chip select edges.
// RL11 - Both lines carry words most significant bit first.
// RL12 - Host sends control bits first, then data bits.
// RL13 - Device is a shift register passing input to output for chaining.
// RL14 - Chained host clocks whole bytes covering all devices, then releases.
// RL15 - Answer to a frame comes in the following frame.
// RL16 - After a transmission error the next answer is the error response.
// RL17 - First answer after reset or software reset is the reset response.
// RL18 - Write with 11 or read with 00 is a syntax error.
// RL19 - Write to a reserved address is a syntax error, not acted on.
// RL20 - Frames carry primary and secondary address fields plus content.
// RL21 - Read of a reserved address answers with the standard diagnosis.
// RL22 - Decoded command and write strobe reach the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module dcs_spi_slave
  import dcs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Serial link pins
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic si,
  output logic so,
  output logic so_oe_n,
  // Core status
  input wire logic sleep,
  input wire logic soft_reset,
  input wire logic [dcs_pkg::DCS_FRAME_W-1:0] std_diag,
  input wire logic [dcs_pkg::DCS_DATA_W-1:0] rd_data,
  output logic [dcs_pkg::DCS_PADDR_W-1:0] rd_primary_address_field,
  output logic [dcs_pkg::DCS_SADDR_W-1:0] rd_secondary_address_field,
  output logic transfer_error_flag,
  // Decoded write command
  output logic cmd_valid,
  output logic [dcs_pkg::DCS_PADDR_W-1:0] cmd_primary_address_field,
  output logic [dcs_pkg::DCS_SADDR_W-1:0] cmd_secondary_address_field,
  output logic [dcs_pkg::DCS_DATA_W-1:0] cmd_data
);

  import dcs_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [2:0] pins_s;
  logic sclk_s, csn_s, si_s;
  logic sclk_prev_q, sclk_prev_d;
  logic csn_prev_q, csn_prev_d;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise;

  dcs_sync #(.W(3)) u_pin_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in({sclk, chip_select_n, si}),
    .sync_out(pins_s)
  );

  assign sclk_s = pins_s[2];
  assign csn_s = pins_s[1];
  assign si_s = pins_s[0];

  always_comb begin
    sclk_prev_d = sclk_s;
    csn_prev_d = csn_s;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk_prev_q <= 1'b0;
      csn_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_prev_d;
      csn_prev_q <= csn_prev_d;
    end
  end

  assign sclk_rise = sclk_s && !sclk_prev_q;
  assign sclk_fall = !sclk_s && sclk_prev_q;
  assign cs_fall = !csn_s && csn_prev_q;
  assign cs_rise = csn_s && !csn_prev_q;

  // ----------------------------------------------------------------
  // Frame decode helpers
  // ----------------------------------------------------------------
  dcs_link_state_t state_q, state_d;
  logic [DCS_FRAME_W-1:0] shreg_q, shreg_d;
  logic [DCS_CNT_W-1:0] bit_cnt_q, bit_cnt_d;
  logic [DCS_MOD_W-1:0] mod_q, mod_d;
  logic so_q, so_d;
  logic frame_ok, addr_ok, end_frame;
  logic [1:0] cmd_code;
  logic [DCS_PADDR_W-1:0] frm_paddr;
  logic [DCS_SADDR_W-1:0] frm_saddr;
  logic [DCS_FRAME_W-1:0] rsp_word;

  assign cmd_code = shreg_q[DCS_CMD_HI:DCS_CMD_LO];
  assign frm_paddr = shreg_q[DCS_PADDR_HI:DCS_PADDR_LO]; // RL20
  assign frm_saddr = shreg_q[DCS_SADDR_HI:DCS_SADDR_LO]; // RL20
  assign addr_ok = DCS_ADDR_MAP[{frm_paddr, frm_saddr}];
  // Total mod 8 is enough once 16 is reached, as 16 is a whole byte count
  assign frame_ok = (bit_cnt_q == DCS_MIN_BITS) && (mod_q == DCS_MOD_ZERO); // RL4
  assign end_frame = cs_rise && (state_q == DCS_LINK_ACTIVE); // RL3

  // ----------------------------------------------------------------
  // Response selection, error flag and decoded command
  // ----------------------------------------------------------------
  dcs_rsp_sel_t rsp_sel_q, rsp_sel_d;
  logic ter_q, ter_d;
  logic cmd_valid_q, cmd_valid_d;
  logic [DCS_PADDR_W-1:0] cmd_paddr_q, cmd_paddr_d, rd_paddr_q, rd_paddr_d;
  logic [DCS_SADDR_W-1:0] cmd_saddr_q, cmd_saddr_d, rd_saddr_q, rd_saddr_d;
  logic [DCS_DATA_W-1:0] cmd_data_q, cmd_data_d;

  always_comb begin
    rsp_sel_d = rsp_sel_q;
    ter_d = ter_q;
    cmd_valid_d = 1'b0;
    cmd_paddr_d = cmd_paddr_q;
    cmd_saddr_d = cmd_saddr_q;
    cmd_data_d = cmd_data_q;
    rd_paddr_d = rd_paddr_q;
    rd_saddr_d = rd_saddr_q;
    if (end_frame) begin
      if (!frame_ok) begin
        ter_d = 1'b1; // RL4
        rsp_sel_d = DCS_SEL_TER; // RL16
      end else begin
        ter_d = 1'b0;
        if (cmd_code == DCS_CMD_WRITE && addr_ok) begin
          cmd_valid_d = 1'b1; // RL9 RL22
          cmd_paddr_d = frm_paddr;
          cmd_saddr_d = frm_saddr;
          cmd_data_d = shreg_q[DCS_DATA_HI:DCS_DATA_LO];
          rsp_sel_d = DCS_SEL_DIAG;
        end else if (cmd_code == DCS_CMD_READ && addr_ok) begin
          rd_paddr_d = frm_paddr;
          rd_saddr_d = frm_saddr;
          rsp_sel_d = DCS_SEL_READ; // RL15
        end else if (cmd_code == DCS_CMD_READ) begin
          rsp_sel_d = DCS_SEL_DIAG; // RL21
        end else begin
          rsp_sel_d = DCS_SEL_SYNTAX; // RL18 RL19
        end
      end
    end
    // Software reset outranks a frame closing in the same cycle for the response choice; flag and strobe still follow the frame
    if (soft_reset) begin
      rsp_sel_d = DCS_SEL_RESET; // RL17
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rsp_sel_q <= DCS_SEL_RESET; // RL17
      ter_q <= 1'b0;
      cmd_valid_q <= 1'b0;
      cmd_paddr_q <= '0;
      cmd_saddr_q <= '0;
      cmd_data_q <= '0;
      rd_paddr_q <= '0;
      rd_saddr_q <= '0;
    end else begin
      rsp_sel_q <= rsp_sel_d;
      ter_q <= ter_d;
      cmd_valid_q <= cmd_valid_d;
      cmd_paddr_q <= cmd_paddr_d;
      cmd_saddr_q <= cmd_saddr_d;
      cmd_data_q <= cmd_data_d;
      rd_paddr_q <= rd_paddr_d;
      rd_saddr_q <= rd_saddr_d;
    end
  end

  always_comb begin
    unique case (rsp_sel_q)
      DCS_SEL_RESET: rsp_word = DCS_RSP_RESET;
      DCS_SEL_TER: rsp_word = DCS_RSP_TER;
      DCS_SEL_SYNTAX: rsp_word = DCS_RSP_SYNTAX;
      DCS_SEL_DIAG: rsp_word = std_diag;
      DCS_SEL_READ: rsp_word = {DCS_RSP_READ_TAG, rd_paddr_q, rd_saddr_q, rd_data};
      default: rsp_word = DCS_RSP_SYNTAX;
    endcase
  end

  // ----------------------------------------------------------------
  // Link state, shift register and bit counters
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    shreg_d = shreg_q;
    bit_cnt_d = bit_cnt_q;
    mod_d = mod_q;
    so_d = so_q;
    unique case (state_q)
      DCS_LINK_IDLE: begin
        // Clock and input are ignored until a frame opens
        if (cs_fall && !sleep) begin // RL8
          state_d = DCS_LINK_ACTIVE; // RL1
          shreg_d = rsp_word; // RL6
          bit_cnt_d = '0;
          mod_d = '0;
          so_d = ter_q | si_s; // RL7
        end
      end
      DCS_LINK_ACTIVE: begin
        if (cs_rise) begin
          state_d = DCS_LINK_IDLE; // RL5
        end else begin
          if (sclk_rise) begin
            so_d = shreg_q[DCS_FRAME_W-1]; // RL2 RL11
          end
          if (sclk_fall) begin
            // Bits beyond this device's share walk on to the next device
            shreg_d = {shreg_q[DCS_FRAME_W-2:0], si_s}; // RL2 RL11 RL13
            mod_d = mod_q + DCS_MOD_ONE;
            if (bit_cnt_q != DCS_MIN_BITS) begin
              bit_cnt_d = bit_cnt_q + DCS_CNT_ONE;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= DCS_LINK_IDLE;
      shreg_q <= '0;
      bit_cnt_q <= '0;
      mod_q <= '0;
      so_q <= 1'b0;
    end else begin
      state_q <= state_d;
      shreg_q <= shreg_d;
      bit_cnt_q <= bit_cnt_d;
      mod_q <= mod_d;
      so_q <= so_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic so_oe_n_q, so_oe_n_d;

  always_comb begin
    so_oe_n_d = (state_d != DCS_LINK_ACTIVE); // RL5 RL8
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      so_oe_n_q <= 1'b1;
    end else begin
      so_oe_n_q <= so_oe_n_d;
    end
  end

  assign so = so_q;
  assign so_oe_n = so_oe_n_q;
  assign transfer_error_flag = ter_q;
  assign cmd_valid = cmd_valid_q;
  assign cmd_primary_address_field = cmd_paddr_q;
  assign cmd_secondary_address_field = cmd_saddr_q;
  assign cmd_data = cmd_data_q;
  assign rd_primary_address_field = rd_paddr_q;
  assign rd_secondary_address_field = rd_saddr_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_open;
    cs_fall && !sleep && state_q == DCS_LINK_IDLE;
  endsequence

  sequence s_good_write;
    end_frame && frame_ok && cmd_code == DCS_CMD_WRITE && addr_ok;
  endsequence

  sequence s_good_read;
    end_frame && frame_ok && cmd_code == DCS_CMD_READ && addr_ok;
  endsequence

  a_open_loads_rsp: assert property (s_open |=> state_q == DCS_LINK_ACTIVE && shreg_q == $past(rsp_word)) // RL1 RL6
    else $error("frame open did not load response");
  a_open_drives_ter: assert property (s_open |=> !so_oe_n && so == $past(ter_q | si_s)) // RL7
    else $error("first output level is not error flag OR input");
  a_sleep_keeps_off: assert property (cs_fall && sleep && state_q == DCS_LINK_IDLE |=> so_oe_n [*2]) // RL8
    else $error("output driven while asleep");
  a_idle_off: assert property (state_q == DCS_LINK_IDLE |-> so_oe_n) // RL5
    else $error("output driven outside a frame");
  a_idle_ignores: assert property (state_q == DCS_LINK_IDLE && !cs_fall |=> $stable(shreg_q)) // RL5
    else $error("shift register moved outside a frame");
  a_fall_samples: assert property (state_q == DCS_LINK_ACTIVE && !cs_rise && sclk_fall
      |=> shreg_q == {$past(shreg_q[DCS_FRAME_W-2:0]), $past(si_s)}) // RL2 RL11 RL13
    else $error("input bit not shifted in msb first");
  a_rise_shifts: assert property (state_q == DCS_LINK_ACTIVE && !cs_rise && sclk_rise
      |=> so == $past(shreg_q[DCS_FRAME_W-1])) // RL2 RL11
    else $error("output bit not taken from shift register msb");
  a_bad_count: assert property (end_frame && !frame_ok && !soft_reset
      |=> ter_q && !cmd_valid && rsp_sel_q == DCS_SEL_TER) // RL4 RL16
    else $error("bad bit count not flagged");
  a_write_strobe: assert property (s_good_write |=> cmd_valid ##1 !cmd_valid) // RL9 RL22
    else $error("write strobe missing or longer than one cycle");
  a_write_fields: assert property (s_good_write |=> cmd_data == $past(shreg_q[DCS_DATA_HI:DCS_DATA_LO])
      && cmd_primary_address_field == $past(frm_paddr)) // RL9 RL20
    else $error("write fields do not match frame");
  a_read_next: assert property ((s_good_read and !soft_reset) |=> rsp_sel_q == DCS_SEL_READ) // RL15
    else $error("read answer not queued for next frame");
  a_syntax_err: assert property (end_frame && frame_ok && !soft_reset
      && (cmd_code == DCS_CMD_BAD_WRITE || cmd_code == DCS_CMD_BAD_READ || (cmd_code == DCS_CMD_WRITE && !addr_ok))
      |=> rsp_sel_q == DCS_SEL_SYNTAX && !cmd_valid) // RL18 RL19
    else $error("syntax error not answered");
  a_reserved_read: assert property (end_frame && frame_ok && cmd_code == DCS_CMD_READ && !addr_ok && !soft_reset
      |=> rsp_sel_q == DCS_SEL_DIAG) // RL21
    else $error("reserved read not answered with diagnosis");
  a_soft_reset: assert property (soft_reset |=> rsp_sel_q == DCS_SEL_RESET) // RL17
    else $error("software reset did not select reset response");

endmodule // dcs_spi_slave
`default_nettype wire

// ===== verif/dcs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Host side serial master, 160 ns clock
// ----------------------------------------
module dcs_host_model (
  // Core clock for pacing
  input wire logic clk,
  // Serial link
  output logic sclk,
  output logic chip_select_n,
  output logic host_data_out,
  input wire logic host_data_in,
  input wire logic so_oe_n
);
  logic [31:0] rx;
  logic first_bit;
  logic first_oe_n;
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    host_data_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Clock stands low around chip select edges; bits leave MSB first
  task automatic frame(input int nb, input logic [31:0] tx, input logic lead);
    rx = '0;
    host_data_out = lead;
    tick(2);
    chip_select_n = 1'b0;
    tick(8);
    first_bit = host_data_in;
    first_oe_n = so_oe_n;
    for (int i = nb - 1; i >= 0; i--) begin
      sclk = 1'b1;
      host_data_out = tx[i];
      tick(8);
      rx = {rx[30:0], host_data_in};
      sclk = 1'b0;
      tick(8);
    end
    chip_select_n = 1'b1;
    tick(10);
  endtask
  // Activity while deselected
  task automatic stray();
    for (int i = 0; i < 4; i++) begin
      sclk = 1'b1;
      host_data_out = ~host_data_out;
      tick(8);
      sclk = 1'b0;
      tick(8);
    end
  endtask
endmodule // dcs_host_model
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dcs_pkg::*;
  logic clk = 1'b0;
  logic resetn, sclk, chip_select_n, si, so, so_oe_n, sleep, soft_reset, xfer_err, cmd_valid;
  logic so_last = 1'b0;
  logic flag_exp, pin_in;
  logic [15:0] std_diag, exp_rsp;
  logic [7:0] rd_data, cmd_data;
  logic [3:0] rd_pa, cmd_pa;
  logic [1:0] rd_sa, cmd_sa;
  logic [13:0] last_cmd;
  logic [31:0] lfsr_q;
  int err_total = 0;
  int cmp_count = 0;
  int n_cmd = 0;
  int n_oe = 0;
  int nb_pick[8] = '{16, 16, 16, 24, 32, 8, 17, 16};
  int nb_tab[12] = '{16, 16, 16, 8, 17, 16, 16, 16, 15, 24, 32, 16};
  logic [31:0] tx_tab[12] = '{32'h803c, 32'h5100, 32'h91a5, 32'ha5, 32'h15100, 32'h5200,
    32'h92ff, 32'hc11e, 32'h1111, 32'ha50100, 32'h12345100, 32'h803c};

  always #5 clk = ~clk;
  // Core register content follows the read address
  assign rd_data = {2'b00, rd_pa, rd_sa} ^ 8'ha5;
  // Released pin has no pull: show the inverse of the last level
  assign pin_in = so_oe_n ? ~so_last : so;
  always @(posedge clk) begin
    if (!so_oe_n) begin
      so_last <= so;
      n_oe <= n_oe + 1;
    end
    if (cmd_valid) begin
      n_cmd <= n_cmd + 1;
      last_cmd <= {cmd_pa, cmd_sa, cmd_data};
    end
  end

  dcs_host_model i_host (.clk(clk), .sclk(sclk), .chip_select_n(chip_select_n),
    .host_data_out(si), .host_data_in(pin_in), .so_oe_n(so_oe_n));
  dcs_spi_slave i_dut (.clk(clk), .resetn(resetn), .sclk(sclk), .chip_select_n(chip_select_n),
    .si(si), .so(so), .so_oe_n(so_oe_n), .sleep(sleep), .soft_reset(soft_reset),
    .std_diag(std_diag), .rd_data(rd_data), .rd_primary_address_field(rd_pa),
    .rd_secondary_address_field(rd_sa), .transfer_error_flag(xfer_err), .cmd_valid(cmd_valid),
    .cmd_primary_address_field(cmd_pa), .cmd_secondary_address_field(cmd_sa),
    .cmd_data(cmd_data));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int i = 0; i < 32; i++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction
  function automatic logic [15:0] rsp_for(input logic [15:0] c);
    logic imp;
    imp = c[13:8] < 6'd18;
    if (c[15:14] == DCS_CMD_WRITE) return imp ? std_diag : DCS_RSP_SYNTAX;
    if (c[15:14] == DCS_CMD_READ)
      return imp ? {DCS_RSP_READ_TAG, c[13:8], {2'b00, c[13:8]} ^ 8'ha5} : std_diag;
    return DCS_RSP_SYNTAX;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("Checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // One frame, checked against the answer owed by the previous one
  task automatic xfer(input int nb, input logic [31:0] tx);
    logic [15:0] c;
    logic ok, lead, wr, rd;
    int n0, o0;
    c = tx[15:0];
    ok = (nb >= 16) && (nb % 8 == 0);
    lfsr_q = lfsr(lfsr_q);
    lead = lfsr_q[5];
    n0 = n_cmd;
    o0 = n_oe;
    i_host.frame(nb, tx, lead);
    if (sleep) begin
      check("oe in sleep", n_oe - o0, 0);
      check("cmd in sleep", n_cmd - n0, 0);
    end else begin
      check("so at select", {i_host.first_oe_n, i_host.first_bit}, {1'b0, flag_exp | lead});
      if (nb >= 16) check("answer", i_host.rx >> (nb - 16), exp_rsp);
      if (nb > 16) check("chain", i_host.rx & ((32'h1 << (nb - 16)) - 32'h1), (tx >> 16) & ((32'h1 << (nb - 16)) - 32'h1));
      check("flag", xfer_err, !ok);
      wr = ok && c[15:14] == DCS_CMD_WRITE && c[13:8] < 6'd18;
      rd = ok && c[15:14] == DCS_CMD_READ && c[13:8] < 6'd18;
      check("strobes", n_cmd - n0, wr);
      if (wr) check("write", last_cmd, c[13:0]);
      if (rd) check("read addr", {rd_pa, rd_sa}, c[13:8]);
      flag_exp = !ok;
      std_diag = lfsr_q[17:2];
      exp_rsp = ok ? rsp_for(c) : DCS_RSP_TER;
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int o0, c0;
    resetn = 1'b0;
    sleep = 1'b0;
    soft_reset = 1'b0;
    std_diag = 16'h0;
    lfsr_q = 32'hd895;
    exp_rsp = DCS_RSP_RESET;
    flag_exp = 1'b0;
    i_host.tick(5);
    resetn = 1'b1;
    i_host.tick(4);
    for (int i = 0; i < 12; i++) xfer(nb_tab[i], tx_tab[i]);
    for (int i = 0; i < 40; i++) xfer(nb_pick[lfsr_q[30:28]], lfsr_q & 32'hffff_dfff);
    sleep = 1'b1;
    xfer(16, 32'h803c);
    sleep = 1'b0;
    o0 = n_oe;
    c0 = n_cmd;
    i_host.stray();
    check("oe idle", n_oe - o0, 0);
    check("cmd idle", n_cmd - c0, 0);
    xfer(16, 32'h91a5);
    soft_reset = 1'b1;
    i_host.tick(1);
    soft_reset = 1'b0;
    exp_rsp = DCS_RSP_RESET;
    xfer(16, 32'h5100);
    resetn = 1'b0;
    i_host.tick(5);
    resetn = 1'b1;
    i_host.tick(4);
    exp_rsp = DCS_RSP_RESET;
    flag_exp = 1'b0;
    xfer(16, 32'h5200);
    results();
  end
  initial begin
    #800_000;
    err_total++;
    $display("BAD watchdog expected finish seen timeout");
    results();
  end
endmodule // testbench
`default_nettype wire
